//--- include/dlpm_regs.svh
`ifndef DLPM_REGS_SVH
`define DLPM_REGS_SVH
// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define DLPM_ADDR_CTRL 8'h00
`define DLPM_ADDR_STAT 8'h04
`define DLPM_ADDR_SRRATE 8'h08
// ----------------------------------------------------------------
// ctrl fields
// ----------------------------------------------------------------
`define DLPM_CTRL_LPASR_LO 0
`define DLPM_CTRL_ODT_OFF 2
`define DLPM_CTRL_PARK_LO 3
`define DLPM_CTRL_CAPAR 6
`define DLPM_CTRL_CAL 7
`define DLPM_CTRL_RESET 32'h0000_0000
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DLPM_CLK_PERIOD_NS 40
`define DLPM_CPDED_NS 10
`define DLPM_CPDED_CYC \
  ((`DLPM_CPDED_NS + `DLPM_CLK_PERIOD_NS - 1) / `DLPM_CLK_PERIOD_NS)
`define DLPM_RATE_NORMAL 4'h4
`define DLPM_RATE_REDUCED 4'h2
`define DLPM_RATE_EXT 4'h8
`define DLPM_RATE_ASR_COOL 4'h2
`define DLPM_RATE_ASR_WARM 4'h4
`define DLPM_RATE_ASR_HOT 4'h8
`define DLPM_TEMP_45C 8'h2d
`define DLPM_TEMP_85C 8'h55
`endif

//--- include/dlpm_pkg.sv
package dlpm_pkg;
  typedef enum logic [2:0] {
    DLPM_IDLE = 3'b000,
    DLPM_PD_DRAIN = 3'b001,
    DLPM_PD = 3'b011,
    DLPM_SR = 3'b010,
    DLPM_SR_EXIT = 3'b110
  } dlpm_state_e;
  typedef enum logic [2:0] {
    DLPM_CMD_DES = 3'd0,
    DLPM_CMD_NOP = 3'd1,
    DLPM_CMD_ACT = 3'd2,
    DLPM_CMD_PRE = 3'd3,
    DLPM_CMD_REF = 3'd4,
    DLPM_CMD_SRE = 3'd5,
    DLPM_CMD_OTHER = 3'd6
  } dlpm_cmd_e;
endpackage

//--- rtl/dlpm_axil.sv
`timescale 1ns/1ps
`default_nettype none
`include "dlpm_regs.svh"
module dlpm_axil (
  input wire logic core_clk_in, // clock
  input wire logic rst_n_in, // async reset
  input wire logic [7:0] awaddr_in, // write address
  input wire logic awvalid_in, // write address valid
  output logic awready_out, // write address ready
  input wire logic [31:0] wdata_in, // write data
  input wire logic [3:0] wstrb_in, // byte strobes
  input wire logic wvalid_in, // write data valid
  output logic wready_out, // write data ready
  output logic [1:0] bresp_out, // write response
  output logic bvalid_out, // write response valid
  input wire logic bready_in, // response ready
  input wire logic [7:0] araddr_in, // read address
  input wire logic arvalid_in, // read address valid
  output logic arready_out, // read address ready
  output logic [31:0] rdata_out, // read data
  output logic [1:0] rresp_out, // read response
  output logic rvalid_out, // read valid
  input wire logic rready_in, // read ready
  output logic [31:0] ctrl_out, // control register
  input wire logic [31:0] stat_in, // status word
  input wire logic [31:0] rate_in // self refresh rate word
);
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw;
    logic w_got;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [31:0] ctrl;
  } dlpm_axil_s;
  dlpm_axil_s s_q, s_d;
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (awvalid_in && !s_q.aw_got && !s_q.bv) begin
      s_d.aw_got = 1'b1;
      s_d.aw = awaddr_in;
    end
    if (wvalid_in && !s_q.w_got && !s_q.bv) begin
      s_d.w_got = 1'b1;
      s_d.wd = wdata_in;
      s_d.ws = wstrb_in;
    end
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bv = 1'b1;
      s_d.br = 2'b00;
      if (s_q.aw[7:2] == `DLPM_ADDR_CTRL >> 2) begin
        for (int i = 0; i < 4; i++) begin
          if (s_q.ws[i]) begin
            s_d.ctrl[i*8 +: 8] = s_q.wd[i*8 +: 8];
          end
        end
      end else if (s_q.aw[7:2] != `DLPM_ADDR_STAT >> 2 &&
                   s_q.aw[7:2] != `DLPM_ADDR_SRRATE >> 2) begin
        s_d.br = 2'b10;
      end
    end
    if (s_q.bv && bready_in) begin
      s_d.bv = 1'b0;
    end
    if (s_q.rv && rready_in) begin
      s_d.rv = 1'b0;
    end
    if (arvalid_in && !s_q.rv) begin
      s_d.rv = 1'b1;
      s_d.rr = 2'b00;
      unique case (araddr_in[7:2])
        `DLPM_ADDR_CTRL >> 2: s_d.rd = s_q.ctrl;
        `DLPM_ADDR_STAT >> 2: s_d.rd = stat_in;
        `DLPM_ADDR_SRRATE >> 2: s_d.rd = rate_in;
        default: begin
          s_d.rd = 32'h0000_0000;
          s_d.rr = 2'b10;
        end
      endcase
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign awready_out = !s_q.aw_got && !s_q.bv;
  assign wready_out = !s_q.w_got && !s_q.bv;
  assign bvalid_out = s_q.bv;
  assign bresp_out = s_q.br;
  assign arready_out = !s_q.rv;
  assign rvalid_out = s_q.rv;
  assign rdata_out = s_q.rd;
  assign rresp_out = s_q.rr;
  assign ctrl_out = s_q.ctrl;
endmodule // dlpm_axil
`default_nettype wire

//--- rtl/dlpm_srrate.sv
`timescale 1ns/1ps
`default_nettype none
`include "dlpm_regs.svh"
module dlpm_srrate (
  input wire logic core_clk_in, // clock
  input wire logic rst_n_in, // async reset
  input wire logic latch_in, // self refresh entry pulse
  input wire logic [1:0] mode_in, // lpasr mode bits a7:a6
  input wire logic [7:0] temp_in, // die temperature, degrees
  output logic [3:0] rate_out, // self refresh rate per tick
  output logic [1:0] mode_out // mode fixed at entry
);
  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] rate;
  } dlpm_srrate_s;
  dlpm_srrate_s s_q, s_d;
  // ----------------------------------------------------------------
  // rate select
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (latch_in) begin
      s_d.mode = mode_in;
    end
    unique case (s_d.mode)
      2'b00: s_d.rate = `DLPM_RATE_NORMAL;
      2'b01: s_d.rate = `DLPM_RATE_REDUCED;
      2'b10: s_d.rate = `DLPM_RATE_EXT;
      2'b11: begin
        if (temp_in <= `DLPM_TEMP_45C) begin
          s_d.rate = `DLPM_RATE_ASR_COOL;
        end else if (temp_in <= `DLPM_TEMP_85C) begin
          s_d.rate = `DLPM_RATE_ASR_WARM;
        end else begin
          s_d.rate = `DLPM_RATE_ASR_HOT;
        end
      end
    endcase
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign rate_out = s_q.rate;
  assign mode_out = s_q.mode;
endmodule // dlpm_srrate
`default_nettype wire

//--- rtl/dlpm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dlpm_regs.svh"
// Contract
// - mode 11 selects automatic self refresh
// - automatic mode rate follows die temperature
// - mode 00 fixed normal rate to 85C
// - mode 01 reduced rate to 45C
// - mode 10 fixed high rate to 95C
// - cke low with deselect enters power-down
// - accept entry during activate, precharge, refresh
// - closed banks precharge, open banks active power-down
// - power-down disables buffers except clock, cke, reset
// - mr5 a5 keeps or disables odt receiver
// - park termination kept in power-down
// - command receivers off after cke-off delay
// - dll stays enabled in power-down
// - reset low leaves power-down immediately
// - cke high with deselect exits power-down
module dlpm_top #(
  parameter int BANKS = 8
) (
  input wire logic core_clk_in, // clock
  input wire logic rst_n_in, // async reset
  input wire logic cke_in, // clock enable pin
  input wire logic [2:0] cmd_in, // decoded command
  input wire logic [2:0] bank_in, // command bank
  input wire logic inflight_in, // activate/precharge/refresh busy
  input wire logic dll_locked_in, // dll locked
  input wire logic [7:0] temp_in, // die temperature
  input wire logic [7:0] s_axil_awaddr_in, // write address
  input wire logic s_axil_awvalid_in, // write address valid
  output logic s_axil_awready_out, // write address ready
  input wire logic [31:0] s_axil_wdata_in, // write data
  input wire logic [3:0] s_axil_wstrb_in, // write strobes
  input wire logic s_axil_wvalid_in, // write data valid
  output logic s_axil_wready_out, // write data ready
  output logic [1:0] s_axil_bresp_out, // write response
  output logic s_axil_bvalid_out, // write response valid
  input wire logic s_axil_bready_in, // response ready
  input wire logic [7:0] s_axil_araddr_in, // read address
  input wire logic s_axil_arvalid_in, // read address valid
  output logic s_axil_arready_out, // read address ready
  output logic [31:0] s_axil_rdata_out, // read data
  output logic [1:0] s_axil_rresp_out, // read response
  output logic s_axil_rvalid_out, // read valid
  input wire logic s_axil_rready_in, // read ready
  output logic io_buf_en_out, // data and control buffers on
  output logic ca_rx_en_out, // command/address receivers on
  output logic odt_rx_en_out, // odt receiver on
  output logic park_term_en_out, // park termination applied
  output logic dll_en_out, // dll enabled
  output logic pd_active_out, // active power-down
  output logic pd_precharge_out, // precharge power-down
  output logic sr_active_out, // self refresh
  output logic [3:0] sr_rate_out, // self refresh rate
  output logic nop_exit_err_out // illegal command in nop exit
);
  typedef struct packed {
    dlpm_pkg::dlpm_state_e st;
    logic [BANKS-1:0] open;
    logic [3:0] cpded;
    logic nop_ok;
    logic nop_err;
    logic sr_latch;
    logic io_en;
    logic ca_en;
    logic odt_en;
    logic park_en;
    logic dll_en;
    logic pd_act;
    logic pd_pre;
    logic sr;
  } dlpm_top_s;
  dlpm_top_s s_q, s_d;
  logic [31:0] ctrl;
  logic [31:0] stat;
  logic [31:0] rate_word;
  logic [3:0] rate;
  logic [1:0] mode_fixed;
  logic cmd_des;
  logic [2:0] cpded_cyc;
  assign cpded_cyc = 3'(`DLPM_CPDED_CYC);
  assign cmd_des = cmd_in == dlpm_pkg::DLPM_CMD_DES;
  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  dlpm_axil u_axil (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .awaddr_in(s_axil_awaddr_in),
    .awvalid_in(s_axil_awvalid_in),
    .awready_out(s_axil_awready_out),
    .wdata_in(s_axil_wdata_in),
    .wstrb_in(s_axil_wstrb_in),
    .wvalid_in(s_axil_wvalid_in),
    .wready_out(s_axil_wready_out),
    .bresp_out(s_axil_bresp_out),
    .bvalid_out(s_axil_bvalid_out),
    .bready_in(s_axil_bready_in),
    .araddr_in(s_axil_araddr_in),
    .arvalid_in(s_axil_arvalid_in),
    .arready_out(s_axil_arready_out),
    .rdata_out(s_axil_rdata_out),
    .rresp_out(s_axil_rresp_out),
    .rvalid_out(s_axil_rvalid_out),
    .rready_in(s_axil_rready_in),
    .ctrl_out(ctrl),
    .stat_in(stat),
    .rate_in(rate_word)
  );
  // ----------------------------------------------------------------
  // self refresh rate
  // ----------------------------------------------------------------
  dlpm_srrate u_rate (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .latch_in(s_q.sr_latch),
    .mode_in(ctrl[`DLPM_CTRL_LPASR_LO +: 2]),
    .temp_in(temp_in),
    .rate_out(rate),
    .mode_out(mode_fixed)
  );
  assign rate_word = {26'h000_0000, mode_fixed, rate};
  assign stat = {24'h00_0000, dll_locked_in, s_q.nop_err, s_q.nop_ok,
                 s_q.st, s_q.pd_act, s_q.pd_pre};
  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.sr_latch = 1'b0;
    // bank commands count only while the receivers listen
    if (s_q.ca_en) begin
      unique case (cmd_in)
        dlpm_pkg::DLPM_CMD_ACT: s_d.open[bank_in] = 1'b1;
        dlpm_pkg::DLPM_CMD_PRE: s_d.open[bank_in] = 1'b0;
        default: ;
      endcase
    end
    if (s_q.cpded != 4'h0) begin
      s_d.cpded = s_q.cpded - 4'h1;
    end
    unique case (s_q.st)
      dlpm_pkg::DLPM_IDLE: begin
        if (!cke_in && cmd_des) begin
          s_d.st = dlpm_pkg::DLPM_PD_DRAIN;
          s_d.cpded = {1'b0, cpded_cyc};
          s_d.io_en = 1'b0;
          s_d.odt_en = !ctrl[`DLPM_CTRL_ODT_OFF];
        end else if (!cke_in && cmd_in == dlpm_pkg::DLPM_CMD_SRE) begin
          s_d.st = dlpm_pkg::DLPM_SR;
          s_d.sr_latch = 1'b1;
          s_d.nop_ok = !ctrl[`DLPM_CTRL_CAPAR] && !ctrl[`DLPM_CTRL_CAL];
          s_d.sr = 1'b1;
          s_d.io_en = 1'b0;
          s_d.ca_en = 1'b0;
          s_d.odt_en = 1'b0;
          s_d.park_en = 1'b0;
          s_d.dll_en = 1'b0;
        end
      end
      dlpm_pkg::DLPM_PD_DRAIN: begin
        if (s_q.cpded <= 4'h1) begin
          s_d.ca_en = 1'b0;
        end
        if (cke_in && cmd_des) begin
          s_d.st = dlpm_pkg::DLPM_IDLE;
          s_d.io_en = 1'b1;
          s_d.ca_en = 1'b1;
          s_d.odt_en = 1'b1;
        end else if (!inflight_in && s_q.cpded <= 4'h1) begin
          s_d.st = dlpm_pkg::DLPM_PD;
          s_d.pd_act = |s_d.open;
          s_d.pd_pre = ~|s_d.open;
        end
      end
      dlpm_pkg::DLPM_PD: begin
        s_d.dll_en = 1'b1;
        if (cke_in && cmd_des) begin
          s_d.st = dlpm_pkg::DLPM_IDLE;
          s_d.io_en = 1'b1;
          s_d.ca_en = 1'b1;
          s_d.odt_en = 1'b1;
          s_d.pd_act = 1'b0;
          s_d.pd_pre = 1'b0;
        end
      end
      dlpm_pkg::DLPM_SR: begin
        if (cke_in) begin
          s_d.st = dlpm_pkg::DLPM_SR_EXIT;
          s_d.sr = 1'b0;
          s_d.ca_en = 1'b1;
          s_d.park_en = ctrl[`DLPM_CTRL_PARK_LO +: 3] != 3'h0;
          s_d.dll_en = 1'b1;
        end
      end
      dlpm_pkg::DLPM_SR_EXIT: begin
        if (cmd_in == dlpm_pkg::DLPM_CMD_NOP && !s_q.nop_ok) begin
          s_d.nop_err = 1'b1;
        end
        if (cmd_in != dlpm_pkg::DLPM_CMD_NOP) begin
          s_d.st = dlpm_pkg::DLPM_IDLE;
          s_d.io_en = 1'b1;
          s_d.odt_en = 1'b1;
        end
      end
      default: s_d.st = dlpm_pkg::DLPM_IDLE;
    endcase
    if (s_q.st != dlpm_pkg::DLPM_SR && s_q.st != dlpm_pkg::DLPM_SR_EXIT) begin
      s_d.park_en = ctrl[`DLPM_CTRL_PARK_LO +: 3] != 3'h0;
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.io_en <= 1'b1;
      s_q.ca_en <= 1'b1;
      s_q.odt_en <= 1'b1;
      s_q.dll_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign io_buf_en_out = s_q.io_en;
  assign ca_rx_en_out = s_q.ca_en;
  assign odt_rx_en_out = s_q.odt_en;
  assign park_term_en_out = s_q.park_en;
  assign dll_en_out = s_q.dll_en;
  assign pd_active_out = s_q.pd_act;
  assign pd_precharge_out = s_q.pd_pre;
  assign sr_active_out = s_q.sr;
  assign sr_rate_out = rate;
  assign nop_exit_err_out = s_q.nop_err;
endmodule // dlpm_top
`default_nettype wire

//--- bench/dlpm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dlpm_asserts (
  input wire logic core_clk_in, // clock
  input wire logic rst_n_in, // async reset
  input wire logic cke_in, // clock enable pin
  input wire logic [2:0] cmd_in, // command
  input wire logic inflight_in, // busy
  input wire logic s_axil_bready_in, // response ready
  input wire logic s_axil_rready_in, // read ready
  input wire logic [1:0] s_axil_bresp_out, // write response
  input wire logic s_axil_bvalid_out, // write response valid
  input wire logic [31:0] s_axil_rdata_out, // read data
  input wire logic s_axil_rvalid_out, // read valid
  input wire logic io_buf_en_out, // io buffers
  input wire logic ca_rx_en_out, // ca receivers
  input wire logic dll_en_out, // dll
  input wire logic pd_active_out, // active power-down
  input wire logic pd_precharge_out, // precharge power-down
  input wire logic sr_active_out // self refresh
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire pd_any = pd_active_out | pd_precharge_out;
  wire des = cmd_in == dlpm_pkg::DLPM_CMD_DES;
  chk_pd_entry: assert property (
    $fell(io_buf_en_out) && !sr_active_out
    |-> !$past(cke_in) && $past(des))
    else $error("pd entry without cke low");
  chk_ca_delay: assert property (
    $fell(io_buf_en_out) && !sr_active_out
    |-> ca_rx_en_out ##1 !ca_rx_en_out)
    else $error("ca receiver timing");
  chk_pd_buffers: assert property (pd_any
    |-> !io_buf_en_out && !ca_rx_en_out) else $error("buffers on in pd");
  chk_pd_dll: assert property (pd_any |-> dll_en_out)
    else $error("dll off in pd");
  chk_pd_kind: assert property (
    pd_any |-> pd_active_out != pd_precharge_out)
    else $error("pd kind not unique");
  chk_pd_exit: assert property (pd_any && cke_in && des |=> !pd_any)
    else $error("pd exit missed");
  chk_pd_stay: assert property (pd_any && !cke_in |=> pd_any)
    else $error("pd left with cke low");
  chk_wait_busy: assert property (!io_buf_en_out && !pd_any && !cke_in
    && !sr_active_out && inflight_in |=> !pd_any) else $error("pd too early");
  chk_b_hold: assert property (s_axil_bvalid_out && !s_axil_bready_in
    |=> s_axil_bvalid_out && $stable(s_axil_bresp_out)) else $error("b drop");
  chk_r_hold: assert property (s_axil_rvalid_out && !s_axil_rready_in
    |=> s_axil_rvalid_out && $stable(s_axil_rdata_out)) else $error("r drop");
endmodule // dlpm_asserts
bind dlpm_top dlpm_asserts u_chk (.core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in), .cke_in(cke_in), .cmd_in(cmd_in),
  .inflight_in(inflight_in), .s_axil_bready_in(s_axil_bready_in),
  .s_axil_rready_in(s_axil_rready_in), .s_axil_bresp_out(s_axil_bresp_out),
  .s_axil_bvalid_out(s_axil_bvalid_out), .s_axil_rdata_out(s_axil_rdata_out),
  .s_axil_rvalid_out(s_axil_rvalid_out), .io_buf_en_out(io_buf_en_out),
  .ca_rx_en_out(ca_rx_en_out), .dll_en_out(dll_en_out),
  .pd_active_out(pd_active_out), .pd_precharge_out(pd_precharge_out),
  .sr_active_out(sr_active_out));
`default_nettype wire

//--- bench/dlpm_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dlpm_ctl_model (
  input wire logic core_clk_in, // clock
  output logic cke_out = 1'b1, // clock enable
  output logic [2:0] cmd_out = 3'h0, // command
  output logic [2:0] bank_out = 3'h0, // bank
  output logic inflight_out = 1'b0 // act/pre/ref busy
);
  // one command sampled on n+1 edges; cke moves only with deselect or self refresh entry
  // holds of several edges keep the cke pulse minimum
  // no bursts or mode writes are ever pending at cke fall
  // dll always locked at entry, so no dll reset is owed
  // power-down lasts a few cycles, far below nine intervals
  task automatic drive(input logic c, input dlpm_pkg::dlpm_cmd_e k,
                       input logic [2:0] b, input int n);
    @(posedge core_clk_in);
    cke_out <= c;
    cmd_out <= k;
    bank_out <= b;
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic busy(input logic b);
    @(posedge core_clk_in);
    inflight_out <= b;
    #1;
  endtask
endmodule // dlpm_ctl_model
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dlpm_regs.svh"
`define CK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic clk = 0, rst_n = 0, dll = 1, awv = 0, wv = 0, bry = 0;
  logic arv = 0, rry = 0;
  logic [7:0] temp = 8'h1e, awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rd;
  logic [3:0] ws = 4'h0;
  logic [1:0] rs;
  wire logic cke, infl, awr, wr, bv, arr, rv, io, ca, odt, park, dlle;
  wire logic pda, pdp, sra, err;
  wire logic [2:0] cmd, bank;
  wire logic [1:0] br, rr;
  wire logic [31:0] rdo;
  wire logic [3:0] rate;
  int miscompares = 0, total_checks = 0;
  always #20 clk = ~clk;
  dlpm_ctl_model ctl (.core_clk_in(clk), .cke_out(cke), .cmd_out(cmd),
    .bank_out(bank), .inflight_out(infl));
  dlpm_top dut (.core_clk_in(clk), .rst_n_in(rst_n), .cke_in(cke),
    .cmd_in(cmd), .bank_in(bank), .inflight_in(infl), .dll_locked_in(dll),
    .temp_in(temp), .s_axil_awaddr_in(awa), .s_axil_awvalid_in(awv),
    .s_axil_awready_out(awr), .s_axil_wdata_in(wd), .s_axil_wstrb_in(ws),
    .s_axil_wvalid_in(wv), .s_axil_wready_out(wr), .s_axil_bresp_out(br),
    .s_axil_bvalid_out(bv), .s_axil_bready_in(bry),
    .s_axil_araddr_in(ara), .s_axil_arvalid_in(arv),
    .s_axil_arready_out(arr), .s_axil_rdata_out(rdo),
    .s_axil_rresp_out(rr), .s_axil_rvalid_out(rv), .s_axil_rready_in(rry),
    .io_buf_en_out(io), .ca_rx_en_out(ca), .odt_rx_en_out(odt),
    .park_term_en_out(park), .dll_en_out(dlle), .pd_active_out(pda),
    .pd_precharge_out(pdp), .sr_active_out(sra), .sr_rate_out(rate),
    .nop_exit_err_out(err));
  task close_out;
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out;
  end
  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int i;
    @(posedge clk);
    awa <= a; awv <= 1; wd <= d; ws <= 4'hf; wv <= 1; bry <= 1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
      if (bv) begin r = br; bry <= 0; break; end
    end
    if (i == 40) begin miscompares++; close_out; end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int i;
    @(posedge clk);
    ara <= a; arv <= 1; rry <= 1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv) begin d = rdo; r = rr; rry <= 0; break; end
    end
    if (i == 40) begin miscompares++; close_out; end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    `CK({io, ca, odt, dlle, pda, pdp, sra, err}, 8'hf0)
    axr(`DLPM_ADDR_CTRL, rd, rs);
    `CK({rs, rd}, {2'h0, `DLPM_CTRL_RESET})
    axr(8'h40, rd, rs);
    `CK({rs, rd}, {2'h2, 32'h0000_0000})
    axw(8'h44, 32'h0000_0001, rs);
    `CK(rs, 2'h2)
  endtask
  task automatic t_pre_pd;
    axw(`DLPM_ADDR_CTRL, 32'h0000_0008, rs);
    ctl.drive(1, dlpm_pkg::DLPM_CMD_ACT, 3'h5, 0);
    ctl.drive(1, dlpm_pkg::DLPM_CMD_PRE, 3'h5, 0);
    ctl.drive(1, dlpm_pkg::DLPM_CMD_DES, 3'h0, 1);
    ctl.drive(0, dlpm_pkg::DLPM_CMD_DES, 3'h0, 4);
    `CK({pdp, pda, io, ca}, 4'h8)
    `CK({odt, park, dlle}, 3'h7)
    axr(`DLPM_ADDR_STAT, rd, rs);
    `CK({rs, rd}, {2'h0, 32'h0000_008d})
    ctl.drive(1, dlpm_pkg::DLPM_CMD_DES, 3'h0, 2);
    `CK({pdp, pda, io}, 3'h1)
  endtask
  task automatic t_act_pd;
    axw(`DLPM_ADDR_CTRL, 32'h0000_0004, rs);
    ctl.drive(1, dlpm_pkg::DLPM_CMD_ACT, 3'h2, 1);
    ctl.busy(1);
    ctl.drive(0, dlpm_pkg::DLPM_CMD_DES, 3'h0, 4);
    `CK({pda, pdp, io}, 3'h0)
    ctl.busy(0);
    ctl.drive(0, dlpm_pkg::DLPM_CMD_DES, 3'h0, 2);
    `CK({pda, pdp, odt, park, dlle}, 5'h11)
    @(posedge clk) rst_n <= 0;
    #1;
    `CK({pda, pdp, io, ca}, 4'h3)
    ctl.drive(1, dlpm_pkg::DLPM_CMD_DES, 3'h0, 1);
    @(posedge clk) rst_n <= 1;
    ctl.drive(1, dlpm_pkg::DLPM_CMD_DES, 3'h0, 2);
    `CK({pda, pdp, io, ca}, 4'h3)
  endtask
  task automatic sr_in(input logic [31:0] c, input logic [7:0] t);
    axw(`DLPM_ADDR_CTRL, c, rs);
    temp <= t;
    ctl.drive(0, dlpm_pkg::DLPM_CMD_SRE, 3'h0, 1);
    ctl.drive(0, dlpm_pkg::DLPM_CMD_DES, 3'h0, 3);
  endtask
  task automatic sr_out;
    ctl.drive(1, dlpm_pkg::DLPM_CMD_DES, 3'h0, 0);
    ctl.drive(1, dlpm_pkg::DLPM_CMD_NOP, 3'h0, 3);
    ctl.drive(1, dlpm_pkg::DLPM_CMD_DES, 3'h0, 2);
  endtask
  task automatic t_sr(input logic [1:0] m, input logic [7:0] t,
                      input logic [3:0] e);
    sr_in({30'h0, m}, t);
    `CK({sra, rate}, {1'b1, e})
    axw(`DLPM_ADDR_CTRL, {30'h0, m ^ 2'h1}, rs);
    ctl.drive(0, dlpm_pkg::DLPM_CMD_DES, 3'h0, 2);
    `CK(rate, e)
    sr_out;
    `CK({sra, err}, 2'h0)
  endtask
  task automatic t_asr;
    sr_in(32'h0000_0003, 8'h1e);
    `CK(rate, `DLPM_RATE_ASR_COOL)
    @(posedge clk) temp <= 8'h5a;
    ctl.drive(0, dlpm_pkg::DLPM_CMD_DES, 3'h0, 3);
    `CK(rate, `DLPM_RATE_ASR_HOT)
    axr(`DLPM_ADDR_SRRATE, rd, rs);
    `CK({rs, rd}, {2'h0, 32'h0000_0038})
    @(posedge clk) temp <= 8'h3c;
    ctl.drive(0, dlpm_pkg::DLPM_CMD_DES, 3'h0, 3);
    `CK(rate, `DLPM_RATE_ASR_WARM)
    sr_out;
  endtask
  task automatic t_nop_err;
    sr_in(32'h0000_0040, 8'h3c);
    sr_out;
    `CK({sra, err}, 2'h1)
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    #1;
    t_reset;
    t_pre_pd;
    t_act_pd;
    t_sr(2'h0, 8'h3c, `DLPM_RATE_NORMAL);
    t_sr(2'h1, 8'h1e, `DLPM_RATE_REDUCED);
    t_sr(2'h2, 8'h3c, `DLPM_RATE_EXT);
    t_sr(2'h3, 8'h5a, `DLPM_RATE_ASR_HOT);
    t_asr;
    t_nop_err;
    close_out;
  end
endmodule // tb
`default_nettype wire
